/* File: hdl/lpmc_clk_gate.sv */
// bank of gate enables that change only while their source clock is low
`timescale 1ns/1ps
module lpmc_clk_gate #(
    parameter int WIDTH = 9
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] gate_req,
    input wire logic [WIDTH-1:0] src_low,
    output logic [WIDTH-1:0] gate_en
);
    initial begin
        if (WIDTH < 1) $error("lpmc_clk_gate: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] gate_en_reg;
    logic [WIDTH-1:0] gate_en_next;

    // a bit follows its request only in a low phase, so no pulse is cut
    assign gate_en_next = (gate_req & src_low) | (gate_en_reg & ~src_low);
    assign gate_en = gate_en_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gate_en_reg <= '1;
        end else begin
            gate_en_reg <= gate_en_next;
        end
    end

    a_gate_low_only: assert property (
        @(posedge clk_sys) disable iff (reset)
        ((gate_en_reg ^ $past(gate_en_reg)) & ~$past(src_low)) == '0)
        else $error("gate changed while its clock was high");

endmodule : lpmc_clk_gate

/* File: hdl/lpmc_ctrl.sv */
// operating mode controller: mode register, sleep sequencing and gate control
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "lpmc_defs.svh"

//Contract
// - Software picks the run state or one of six sleep levels through the mode field.
// - In the run state every clock and enable output is on.
// - Sleep level 0 stops processor and main clock, keeps aux, subsystem clock and loop.
// - Sleep level 1 also stops the loop control while aux and subsystem clocks run.
// - Sleep level 2 stops the oscillator clock but keeps bias generator and aux clock.
// - Sleep level 3 also stops the bias generator, leaving only the aux clock.
// - Sleep level 4 also stops aux clock and crystal oscillator, keeping data.
// - Shutdown switches the core regulator off and keeps no state.
// - Shutdown is left only by the reset pin or a port one or port two pin event.
// - An interrupt in a sleep level restarts all clocks, and return re-enters that level.
// - The reset pin is an active-low reset, or a nonmaskable interrupt when so set.
module lpmc_ctrl #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16,
    parameter int BOOT_CYCLES = `LPMC_BOOT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    input wire logic irq_req,
    input wire logic irq_return,
    input wire logic port_one_pins_wake,
    input wire logic port_two_pins_wake,
    input wire logic rst_nmi_n,
    input wire logic main_clk_low,
    input wire logic aux_clk_low,
    input wire logic subsystem_clock_low,
    input wire logic digital_osc_clock_low,
    output logic cpu_en,
    output logic main_clk_en,
    output logic aux_clk_en,
    output logic subsystem_clock_en,
    output logic freq_locked_loop_en,
    output logic digital_osc_clock_en,
    output logic osc_bias_en,
    output logic crystal_osc_en,
    output logic regulator_en,
    output logic core_reset_req,
    output logic nmi_req
);
    localparam int CNT_W = 12;

    initial begin
        if (BOOT_CYCLES < 1 || BOOT_CYCLES > 4095) $error("lpmc_ctrl: BOOT_CYCLES out of range");
        if (DATA_W < 13) $error("lpmc_ctrl: DATA_W must be at least 13");
        if (ADDR_W < 3) $error("lpmc_ctrl: ADDR_W must be at least 3");
    end

    // gate table per software mode
    function automatic lpmc_pkg::lpmc_gate_t mode_gates(input logic [2:0] m);
        lpmc_pkg::lpmc_gate_t g;
        g = `LPMC_GATES_RUN;
        case (m)
            lpmc_pkg::sleep_level_0: g = `LPMC_GATES_S0;
            lpmc_pkg::sleep_level_1: g = `LPMC_GATES_S1;
            lpmc_pkg::sleep_level_2: g = `LPMC_GATES_S2;
            lpmc_pkg::sleep_level_3: g = `LPMC_GATES_S3;
            lpmc_pkg::sleep_level_4: g = `LPMC_GATES_S4;
            lpmc_pkg::sleep_level_shutdown: g = `LPMC_GATES_OFF;
            default: g = `LPMC_GATES_RUN;
        endcase
        return g;
    endfunction : mode_gates

    lpmc_pkg::lpmc_state_e state_reg;
    lpmc_pkg::lpmc_state_e state_next;
    logic [2:0] mode_reg;
    logic [2:0] mode_next;
    logic nmi_mode_reg;
    logic nmi_mode_next;
    logic shut_wake_reg;
    logic shut_wake_next;
    logic [CNT_W-1:0] boot_cnt_reg;
    logic [CNT_W-1:0] boot_cnt_next;
    logic core_reset_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    lpmc_pkg::lpmc_gate_t gate_req;
    lpmc_pkg::lpmc_gate_t gate_en;
    lpmc_pkg::lpmc_gate_t src_low;
    logic pin_reset;
    logic nmi_pulse;

    // bus decode
    wire sel_ctrl = bus_addr == ADDR_W'(`LPMC_CTRL_OFS);
    wire sel_stat = bus_addr == ADDR_W'(`LPMC_STAT_OFS);
    wire bus_live = state_reg != lpmc_pkg::ST_SHUT && state_reg != lpmc_pkg::ST_BOOT;
    wire wr_ctrl = bus_wr && sel_ctrl && bus_live;
    wire wr_stat = bus_wr && sel_stat && bus_live;
    wire [2:0] w_mode = bus_wdata[`LPMC_CTRL_MODE_LSB +: 3];
    wire w_mode_ok = w_mode != 3'h7;

    // wake conditions
    wire sleep_wake = irq_req || nmi_pulse;
    wire shut_wake = port_one_pins_wake || port_two_pins_wake || !rst_nmi_n;
    wire boot_done = boot_cnt_reg == CNT_W'(BOOT_CYCLES - 1);
    wire [2:0] mode_eff = wr_ctrl && w_mode_ok ? w_mode : mode_reg;
    wire to_shut = mode_eff == lpmc_pkg::sleep_level_shutdown;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lpmc_pkg::ST_RUN: begin
                if (wr_ctrl && w_mode_ok && w_mode != lpmc_pkg::full_run_state) begin
                    state_next = to_shut ? lpmc_pkg::ST_SHUT : lpmc_pkg::ST_SLEEP;
                end
            end
            lpmc_pkg::ST_SLEEP: begin
                if (sleep_wake) begin
                    state_next = lpmc_pkg::ST_SERVICE;
                end
            end
            lpmc_pkg::ST_SERVICE: begin
                if (irq_return) begin
                    if (mode_eff == lpmc_pkg::full_run_state) begin
                        state_next = lpmc_pkg::ST_RUN;
                    end else begin
                        state_next = to_shut ? lpmc_pkg::ST_SHUT : lpmc_pkg::ST_SLEEP;
                    end
                end
            end
            lpmc_pkg::ST_SHUT: begin
                if (shut_wake) begin
                    state_next = lpmc_pkg::ST_BOOT;
                end
            end
            lpmc_pkg::ST_BOOT: begin
                if (boot_done && !pin_reset) begin
                    state_next = lpmc_pkg::ST_RUN;
                end
            end
        endcase
        if (pin_reset) begin
            state_next = lpmc_pkg::ST_BOOT;
        end
    end

    // boot leaves mode and nmi setting as at power-up; the shutdown wake flag is kept
    assign mode_next = state_next == lpmc_pkg::ST_BOOT ? 3'h0 : mode_eff;
    assign nmi_mode_next = state_next == lpmc_pkg::ST_BOOT ? 1'b0 :
                           wr_ctrl ? bus_wdata[`LPMC_CTRL_NMI_BIT] : nmi_mode_reg;
    assign boot_cnt_next = state_reg == lpmc_pkg::ST_BOOT && !pin_reset && !boot_done ?
                           boot_cnt_reg + CNT_W'(1) : '0;
    // hardware set wins over a software clear in the same cycle
    wire shut_exit = state_reg == lpmc_pkg::ST_SHUT && shut_wake;
    assign shut_wake_next = shut_exit ||
                            (shut_wake_reg && !(wr_stat && bus_wdata[`LPMC_STAT_SHUTWAKE_BIT]));

    // gate requests follow the state; service and boot run everything
    always_comb begin
        gate_req = `LPMC_GATES_RUN;
        if (state_next == lpmc_pkg::ST_SLEEP || state_next == lpmc_pkg::ST_SHUT) begin
            gate_req = mode_gates(mode_next);
        end
    end

    // non-clock enables may switch in any cycle
    always_comb begin
        src_low = '1;
        src_low[`LPMC_GATE_MAIN] = main_clk_low;
        src_low[`LPMC_GATE_AUX] = aux_clk_low;
        src_low[`LPMC_GATE_SUB] = subsystem_clock_low;
        src_low[`LPMC_GATE_DCO] = digital_osc_clock_low;
    end

    wire [DATA_W-1:0] ctrl_view = DATA_W'({nmi_mode_reg, 1'b0, mode_reg});
    wire [DATA_W-1:0] stat_view = DATA_W'({shut_wake_reg, 3'h0, state_reg, 1'b0, mode_reg});
    assign rdata_next = !bus_rd ? '0 : sel_ctrl ? ctrl_view : sel_stat ? stat_view : '0;

    lpmc_clk_gate #(
        .WIDTH(9)
    ) u_gate (
        .clk_sys(clk_sys),
        .reset(reset),
        .gate_req(gate_req),
        .src_low(src_low),
        .gate_en(gate_en)
    );

    lpmc_pin_ctl u_pin (
        .clk_sys(clk_sys),
        .reset(reset),
        .rst_nmi_n(rst_nmi_n),
        .nmi_mode(nmi_mode_reg),
        .pin_reset(pin_reset),
        .nmi_pulse(nmi_pulse)
    );

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= lpmc_pkg::ST_RUN;
            mode_reg <= 3'(`LPMC_CTRL_RST);
            nmi_mode_reg <= 1'b0;
            shut_wake_reg <= 1'b0;
            boot_cnt_reg <= '0;
            core_reset_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            nmi_mode_reg <= nmi_mode_next;
            shut_wake_reg <= shut_wake_next;
            boot_cnt_reg <= boot_cnt_next;
            core_reset_reg <= state_next == lpmc_pkg::ST_BOOT;
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign core_reset_req = core_reset_reg;
    assign nmi_req = nmi_pulse;
    assign cpu_en = gate_en[`LPMC_GATE_CPU];
    assign main_clk_en = gate_en[`LPMC_GATE_MAIN];
    assign aux_clk_en = gate_en[`LPMC_GATE_AUX];
    assign subsystem_clock_en = gate_en[`LPMC_GATE_SUB];
    assign freq_locked_loop_en = gate_en[`LPMC_GATE_FLL];
    assign digital_osc_clock_en = gate_en[`LPMC_GATE_DCO];
    assign osc_bias_en = gate_en[`LPMC_GATE_BIAS];
    assign crystal_osc_en = gate_en[`LPMC_GATE_XTAL];
    assign regulator_en = gate_en[`LPMC_GATE_REG];

    wire all_low = main_clk_low && aux_clk_low && subsystem_clock_low && digital_osc_clock_low;
    wire in_sleep = state_reg == lpmc_pkg::ST_SLEEP && state_next == lpmc_pkg::ST_SLEEP;

    a_run_all_on: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_next == lpmc_pkg::ST_RUN && all_low) |=> gate_en == 9'h1ff)
        else $error("run state left a gate closed");

    a_level0_gates: assert property (
        @(posedge clk_sys) disable iff (reset)
        (in_sleep && mode_reg == 3'h1 && all_low) |=>
        !cpu_en && !main_clk_en && aux_clk_en && subsystem_clock_en && freq_locked_loop_en)
        else $error("sleep level 0 gates wrong");

    a_level1_gates: assert property (
        @(posedge clk_sys) disable iff (reset)
        (in_sleep && mode_reg == 3'h2 && all_low) |=>
        !cpu_en && !main_clk_en && !freq_locked_loop_en && aux_clk_en && subsystem_clock_en)
        else $error("sleep level 1 gates wrong");

    a_level2_gates: assert property (
        @(posedge clk_sys) disable iff (reset)
        (in_sleep && mode_reg == 3'h3 && all_low) |=>
        !digital_osc_clock_en && !freq_locked_loop_en && osc_bias_en && aux_clk_en && !cpu_en)
        else $error("sleep level 2 gates wrong");

    a_level3_gates: assert property (
        @(posedge clk_sys) disable iff (reset)
        (in_sleep && mode_reg == 3'h4 && all_low) |=>
        gate_en == 9'h184)
        else $error("sleep level 3 gates wrong");

    a_level4_gates: assert property (
        @(posedge clk_sys) disable iff (reset)
        (in_sleep && mode_reg == 3'h5 && all_low) |=>
        !aux_clk_en && !crystal_osc_en && regulator_en && !subsystem_clock_en)
        else $error("sleep level 4 gates wrong");

    a_shut_reg_off: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SHUT && state_next == lpmc_pkg::ST_SHUT) |=> !regulator_en)
        else $error("regulator on in shutdown");

    a_shut_ignores_irq: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SHUT && !port_one_pins_wake && !port_two_pins_wake
         && rst_nmi_n && !pin_reset) |=> state_reg == lpmc_pkg::ST_SHUT)
        else $error("shutdown left without a pin event");

    a_irq_round_trip: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SLEEP && sleep_wake && !pin_reset) |=>
        state_reg == lpmc_pkg::ST_SERVICE ##1 cpu_en)
        else $error("interrupt did not restart the processor");

    a_return_level: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SERVICE && irq_return && !bus_wr && !pin_reset
         && mode_reg != 3'h0 && mode_reg != 3'h6) |=>
        state_reg == lpmc_pkg::ST_SLEEP && $stable(mode_reg))
        else $error("return did not re-enter the sleep level");

    a_pin_reset_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        pin_reset |=> core_reset_req && mode_reg == 3'h0)
        else $error("reset pin did not reset the core");

    a_shut_boot: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SHUT && port_one_pins_wake) |=>
        state_reg == lpmc_pkg::ST_BOOT && core_reset_req && shut_wake_reg)
        else $error("shutdown wake did not start a boot");

    a_wake_two_boot: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SHUT && port_two_pins_wake) |=>
        state_reg == lpmc_pkg::ST_BOOT && shut_wake_reg)
        else $error("port two wake did not leave shutdown");

    a_pin_wakes_shut: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SHUT && !rst_nmi_n) |=> state_reg == lpmc_pkg::ST_BOOT)
        else $error("reset pin did not leave shutdown");

    a_rdata_idle: assert property (
        @(posedge clk_sys) disable iff (reset)
        !bus_rd |=> bus_rdata == '0)
        else $error("read data stood without a read");

    a_mode7_kept: assert property (
        @(posedge clk_sys) disable iff (reset)
        (wr_ctrl && !w_mode_ok && !pin_reset) |=> $stable(mode_reg))
        else $error("illegal mode code was taken");

    a_run_holds: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_RUN && !wr_ctrl && !pin_reset) |=>
        state_reg == lpmc_pkg::ST_RUN)
        else $error("run state left without a mode write");

    a_service_all_on: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_reg == lpmc_pkg::ST_SERVICE && state_next == lpmc_pkg::ST_SERVICE && all_low)
        |=> gate_en == `LPMC_GATES_RUN)
        else $error("service left a gate closed");

    a_nmi_no_reset: assert property (
        @(posedge clk_sys) disable iff (reset)
        (nmi_mode_reg && !rst_nmi_n) |=> !pin_reset)
        else $error("pin in nmi mode acted as reset");

    a_boot_core_reset: assert property (
        @(posedge clk_sys) disable iff (reset)
        core_reset_req == (state_reg == lpmc_pkg::ST_BOOT))
        else $error("core reset request out of step with boot");

endmodule : lpmc_ctrl

/* File: hdl/lpmc_defs.svh */
// register map, field positions, reset values and timing counts of the mode controller
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

`define LPMC_CTRL_OFS 8'h00
`define LPMC_STAT_OFS 8'h04

`define LPMC_CTRL_MODE_LSB 0
`define LPMC_CTRL_NMI_BIT 4
`define LPMC_STAT_MODE_LSB 0
`define LPMC_STAT_STATE_LSB 4
`define LPMC_STAT_SHUTWAKE_BIT 12

`define LPMC_CTRL_RST 16'h0000

`define LPMC_GATE_CPU 0
`define LPMC_GATE_MAIN 1
`define LPMC_GATE_AUX 2
`define LPMC_GATE_SUB 3
`define LPMC_GATE_FLL 4
`define LPMC_GATE_DCO 5
`define LPMC_GATE_BIAS 6
`define LPMC_GATE_XTAL 7
`define LPMC_GATE_REG 8

`define LPMC_GATES_RUN 9'h1ff
`define LPMC_GATES_S0 9'h1fc
`define LPMC_GATES_S1 9'h1ec
`define LPMC_GATES_S2 9'h1c4
`define LPMC_GATES_S3 9'h184
`define LPMC_GATES_S4 9'h100
`define LPMC_GATES_OFF 9'h000

`define LPMC_CLK_PERIOD_NS 25
`define LPMC_BOOT_HOLD_NS 1000
`define LPMC_BOOT_CYCLES ((`LPMC_BOOT_HOLD_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS)

`endif

/* File: hdl/lpmc_pin_ctl.sv */
// combined reset and nonmaskable interrupt pin handling
`timescale 1ns/1ps
module lpmc_pin_ctl (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic rst_nmi_n,
    input wire logic nmi_mode,
    output logic pin_reset,
    output logic nmi_pulse
);
    logic pin_low_reg;
    logic pin_reset_reg;
    logic nmi_pulse_reg;
    logic fall;

    assign fall = !rst_nmi_n && !pin_low_reg;
    assign pin_reset = pin_reset_reg;
    assign nmi_pulse = nmi_pulse_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_low_reg <= 1'b0;
            pin_reset_reg <= 1'b0;
            nmi_pulse_reg <= 1'b0;
        end else begin
            pin_low_reg <= !rst_nmi_n;
            pin_reset_reg <= !rst_nmi_n && !nmi_mode;
            nmi_pulse_reg <= fall && nmi_mode;
        end
    end

    a_nmi_edge: assert property (
        @(posedge clk_sys) disable iff (reset)
        (nmi_mode && rst_nmi_n ##1 nmi_mode && !rst_nmi_n) |=> nmi_pulse_reg ##1 !nmi_pulse_reg)
        else $error("nmi pulse missing or too long");

endmodule : lpmc_pin_ctl

/* File: hdl/lpmc_pkg.sv */
// types shared by the mode controller files
package lpmc_pkg;

    typedef enum logic [2:0] {
        full_run_state = 3'h0,
        sleep_level_0 = 3'h1,
        sleep_level_1 = 3'h2,
        sleep_level_2 = 3'h3,
        sleep_level_3 = 3'h4,
        sleep_level_4 = 3'h5,
        sleep_level_shutdown = 3'h6
    } lpmc_mode_e;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SLEEP = 5'h02,
        ST_SERVICE = 5'h04,
        ST_SHUT = 5'h08,
        ST_BOOT = 5'h10
    } lpmc_state_e;

    typedef logic [8:0] lpmc_gate_t;

endpackage : lpmc_pkg

/* File: verification/lpmc_core_model.sv */
// processor core and wake source model facing the mode controller
`timescale 1ns/1ps
module lpmc_core_model (
    input wire logic clk_sys,
    input wire logic irq_go,
    input wire logic [3:0] hold,
    input wire logic cpu_en,
    output logic irq_req,
    output logic irq_return,
    output logic main_clk_low,
    output logic aux_clk_low,
    output logic subsystem_clock_low,
    output logic digital_osc_clock_low
);
    logic [3:0] phase_reg = 4'h0;
    int n;
    // source clock phases; all four are low together once every eight cycles
    always @(posedge clk_sys) phase_reg <= phase_reg + 4'h1;
    assign main_clk_low = phase_reg[0];
    assign aux_clk_low = phase_reg[1];
    assign subsystem_clock_low = phase_reg[2];
    assign digital_osc_clock_low = phase_reg[0] | phase_reg[3];
    // handler: wait until the core runs, serve, return; give up if never woken
    initial begin
        irq_req = 1'b0;
        irq_return = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (irq_go) begin
                irq_req <= 1'b1;
                n = 0;
                while (cpu_en !== 1'b1 && n < 24) begin
                    @(posedge clk_sys);
                    n++;
                end
                if (cpu_en === 1'b1) begin
                    repeat (hold) @(posedge clk_sys);
                    irq_return <= 1'b1;
                end
                irq_req <= 1'b0;
                @(posedge clk_sys);
                irq_return <= 1'b0;
            end
        end
    end
endmodule : lpmc_core_model

/* File: verification/testbench.sv */
// self-checking bench of the operating mode controller
`timescale 1ns/1ps
module testbench;
    localparam int BOOT = 4;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] bus_rdata;
    logic irq_req, irq_return, irq_go = 1'b0;
    logic [3:0] hold = 4'h8;
    logic wake_one = 1'b0;
    logic wake_two = 1'b0;
    logic rst_nmi_n = 1'b1;
    logic m_low, a_low, s_low, d_low;
    logic cpu_en, main_en, aux_en, sub_en, fll_en, dco_en, bias_en, xtal_en, reg_en;
    logic core_reset_req, nmi_req;
    logic [8:0] gates;
    logic [31:0] rnd = 32'h058e;
    logic [2:0] m;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int c;

    assign gates = {reg_en, xtal_en, bias_en, dco_en, fll_en, sub_en, aux_en, main_en, cpu_en};
    always #12.5 clk_sys = ~clk_sys;

    lpmc_ctrl #(.BOOT_CYCLES(BOOT)) u_dut (.clk_sys(clk_sys), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .irq_req(irq_req), .irq_return(irq_return),
        .port_one_pins_wake(wake_one), .port_two_pins_wake(wake_two), .rst_nmi_n(rst_nmi_n),
        .main_clk_low(m_low), .aux_clk_low(a_low), .subsystem_clock_low(s_low),
        .digital_osc_clock_low(d_low), .cpu_en(cpu_en), .main_clk_en(main_en),
        .aux_clk_en(aux_en), .subsystem_clock_en(sub_en), .freq_locked_loop_en(fll_en),
        .digital_osc_clock_en(dco_en), .osc_bias_en(bias_en), .crystal_osc_en(xtal_en),
        .regulator_en(reg_en), .core_reset_req(core_reset_req), .nmi_req(nmi_req));

    lpmc_core_model u_core (.clk_sys(clk_sys), .irq_go(irq_go), .hold(hold), .cpu_en(cpu_en),
        .irq_req(irq_req), .irq_return(irq_return), .main_clk_low(m_low), .aux_clk_low(a_low),
        .subsystem_clock_low(s_low), .digital_osc_clock_low(d_low));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic logic [8:0] exp_gates(input logic [2:0] md);
        case (md)
            3'h0: return 9'h1ff;
            3'h1: return 9'h1fc;
            3'h2: return 9'h1ec;
            3'h3: return 9'h1c4;
            3'h4: return 9'h184;
            3'h5: return 9'h100;
            default: return 9'h000;
        endcase
    endfunction : exp_gates

    task automatic end_sim;
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask : rd

    task automatic wait_gates(input logic [8:0] exp);
        int n;
        n = 0;
        while (gates !== exp && n < 16) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, gates}, {7'h00, exp});
    endtask : wait_gates

    task automatic do_irq(input logic to_run, input logic [2:0] md);
        int n;
        @(posedge clk_sys);
        irq_go <= 1'b1;
        hold <= 4'h8 + {2'b00, rnd[1:0]};
        rnd = xs(rnd);
        @(posedge clk_sys);
        irq_go <= 1'b0;
        wait_gates(9'h1ff);
        if (to_run) wr(8'h00, 16'h0000);
        n = 0;
        while (irq_return !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        wait_gates(exp_gates(to_run ? 3'h0 : md));
        rd(8'h04, to_run ? 16'h0010 : 16'h0020 | {13'h0000, md});
    endtask : do_irq

    task automatic boot_check(input logic [15:0] st);
        int n;
        n = 0;
        while (core_reset_req !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        chk({15'h0000, core_reset_req}, 16'h0001);
        wait_gates(9'h1ff);
        repeat (BOOT + 4) @(negedge clk_sys);
        chk({15'h0000, core_reset_req}, 16'h0000);
        rd(8'h04, st);
    endtask : boot_check

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        wait_gates(9'h1ff);
        rd(8'h04, 16'h0010);
        rd(8'h08, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            m = (i < 5) ? 3'(i + 1) : 3'(1 + rnd % 5);
            rnd = xs(rnd);
            wr(8'h00, {13'h0000, m});
            wait_gates(exp_gates(m));
            rd(8'h04, 16'h0020 | {13'h0000, m});
            do_irq(1'b0, m);
            do_irq(1'b1, m);
        end
        wr(8'h00, 16'h0007);
        rd(8'h04, 16'h0010);
        for (int p = 0; p < 3; p++) begin
            wr(8'h00, 16'h0006);
            wait_gates(9'h000);
            @(posedge clk_sys);
            irq_go <= 1'b1;
            @(posedge clk_sys);
            irq_go <= 1'b0;
            wr(8'h00, 16'h0001);
            repeat (10) @(negedge clk_sys);
            chk({7'h00, gates}, 16'h0000);
            repeat (30) @(negedge clk_sys);
            @(posedge clk_sys);
            // third pass wakes through a one-cycle low on the reset pin
            wake_one <= (p == 0);
            wake_two <= (p == 1);
            rst_nmi_n <= (p != 2);
            @(posedge clk_sys);
            wake_one <= 1'b0;
            wake_two <= 1'b0;
            rst_nmi_n <= 1'b1;
            boot_check(16'h1010);
            wr(8'h04, 16'h1000);
            rd(8'h04, 16'h0010);
        end
        wr(8'h00, 16'h0004);
        wait_gates(exp_gates(3'h4));
        @(posedge clk_sys);
        rst_nmi_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_nmi_n <= 1'b1;
        boot_check(16'h0010);
        wr(8'h00, 16'h0012);
        wait_gates(exp_gates(3'h2));
        @(posedge clk_sys);
        rst_nmi_n <= 1'b0;
        c = 0;
        repeat (8) begin
            @(negedge clk_sys);
            if (nmi_req === 1'b1) c++;
        end
        chk(16'(c), 16'h0001);
        chk({15'h0000, core_reset_req}, 16'h0000);
        wait_gates(9'h1ff);
        @(posedge clk_sys);
        rst_nmi_n <= 1'b1;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        wait_gates(9'h1ff);
        rd(8'h04, 16'h0010);
        end_sim();
    end
endmodule : testbench
